/* sleep_clock_gating.sv */
/*
 * Sleep-mode clock gating register with its gate-enable logic,
 * bus-fault check for gated units, and event interrupt.
 * Assumes: one clock, a simple strobe register port, sleep_req and
 * run_gate coming from logic on the same clock, and latch-based
 * clock gate cells downstream that consume unit_clk_en.
 * The run-mode gating word, the sleep gating register, the power state and the auto clock gating choice
 * are the only inputs to the enable mux; deep-sleep gating is
 * handled elsewhere and never reaches this block.
 * Software is expected to keep reserved bits as read and to set
 * every unit it needs in Sleep before requesting Sleep.
 * unit_acc comes from the bus fabric in the access cycle and
 * names a unit by its gating bit position; the fault answer
 * follows one cycle later.
 * Event status is write-one-to-clear, mask has the same layout,
 * and irq is a level that stays up while a masked event is set.
 */
// Strobed register access was left to the implementer.
// How it works
// - gate bit set means unit clocked in Sleep
// - gate bit clear stops clock, holds unit disabled
// - access to gated-off unit answers bus fault
// - gating register resets to all zeros
// - register applies only during Sleep operation
// - sleep settings need auto clock gating set
// - 32-bit read/write register at offset 0x114
// - fixed bit positions for each gated unit
// - reserved bits read zero, ignore writes
// - spare bit positions control nothing
`timescale 1ns/10ps

module sleep_clock_gating
    import sleep_gate_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire logic [sleep_gate_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [sleep_gate_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [sleep_gate_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic [sleep_gate_pkg::DATA_W-1:0] run_gate,
    input  wire logic                          sleep_req,
    input  wire sleep_gate_pkg::unit_acc_type  unit_acc,
    output logic                               unit_fault,
    output logic      [sleep_gate_pkg::DATA_W-1:0] unit_clk_en,
    output logic      [sleep_gate_pkg::DATA_W-1:0] unit_disable,
    output logic                               irq
);
    import sleep_gate_pkg::*;

    // register file state
    logic [DATA_W-1:0] sleep_gate_r;
    logic              auto_gate_r;
    logic [EVT_W-1:0]  evt_stat_r;
    logic [EVT_W-1:0]  evt_mask_r;
    logic [EVT_W-1:0]  evt_stat_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    // gate and mode state
    pwr_state_type     state_r;
    pwr_state_type     state_nxt;
    logic [DATA_W-1:0] gate_en_r;
    logic [DATA_W-1:0] gate_en_nxt;
    logic              fault_r;
    logic              fault_nxt;

    // events
    logic [EVT_W-1:0]  evt_set;
    logic              sleep_enter;
    logic              sleep_leave;

    // address decode helpers
    logic              hit_gate;
    logic              hit_stat;
    logic              hit_mask;
    logic              hit_ctrl;

    // register write enables
    logic              gate_we;
    logic              stat_we;
    logic              mask_we;
    logic              ctrl_we;

    // registered disable vector
    logic [DATA_W-1:0] disable_r;

    // every implemented gating bit, one per controlled unit
    function automatic logic [DATA_W-1:0] unit_mask();
        unit_mask                      = ZERO_WORD;
        unit_mask[COMPARATOR_B_GATE]   = 1'b1;
        unit_mask[COMPARATOR_A_GATE]   = 1'b1;
        unit_mask[GP_COUNTER_D_GATE]   = 1'b1;
        unit_mask[GP_COUNTER_C_GATE]   = 1'b1;
        unit_mask[GP_COUNTER_B_GATE]   = 1'b1;
        unit_mask[GP_COUNTER_A_GATE]   = 1'b1;
        unit_mask[TWO_WIRE_B_GATE]     = 1'b1;
        unit_mask[TWO_WIRE_A_GATE]     = 1'b1;
        unit_mask[SYNC_SERIAL_B_GATE]  = 1'b1;
        unit_mask[SYNC_SERIAL_A_GATE]  = 1'b1;
        unit_mask[ASYNC_SERIAL_C_GATE] = 1'b1;
        unit_mask[ASYNC_SERIAL_B_GATE] = 1'b1;
        unit_mask[ASYNC_SERIAL_A_GATE] = 1'b1;
    endfunction : unit_mask

    // keep only implemented gating bits
    function automatic logic [DATA_W-1:0] impl_bits(
        input logic [DATA_W-1:0] word
    );
        impl_bits = word & unit_mask();
    endfunction : impl_bits

    // true when a unit index names an implemented gating bit
    function automatic logic is_unit(
        input logic [UNIT_W-1:0] idx
    );
        case (idx)
            UNIT_W'(COMPARATOR_B_GATE),
            UNIT_W'(COMPARATOR_A_GATE),
            UNIT_W'(GP_COUNTER_D_GATE),
            UNIT_W'(GP_COUNTER_C_GATE),
            UNIT_W'(GP_COUNTER_B_GATE),
            UNIT_W'(GP_COUNTER_A_GATE),
            UNIT_W'(TWO_WIRE_B_GATE),
            UNIT_W'(TWO_WIRE_A_GATE),
            UNIT_W'(SYNC_SERIAL_B_GATE),
            UNIT_W'(SYNC_SERIAL_A_GATE),
            UNIT_W'(ASYNC_SERIAL_C_GATE),
            UNIT_W'(ASYNC_SERIAL_B_GATE),
            UNIT_W'(ASYNC_SERIAL_A_GATE): begin
                is_unit = 1'b1;
            end
            default: begin
                // spare positions never fault
                is_unit = 1'b0;
            end
        endcase
    endfunction : is_unit

    // register address decode
    assign hit_gate = (reg_addr == SLEEP_GATE_OFF);
    assign hit_stat = (reg_addr == EVT_STAT_OFF);
    assign hit_mask = (reg_addr == EVT_MASK_OFF);
    assign hit_ctrl = (reg_addr == GATE_CTRL_OFF);

    // a write lands only on an exact offset match
    assign gate_we  = reg_wr && hit_gate;
    assign stat_we  = reg_wr && hit_stat;
    assign mask_we  = reg_wr && hit_mask;
    assign ctrl_we  = reg_wr && hit_ctrl;

    // sleep gating register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sleep_gate_r <= SLEEP_GATE_RESET;
        end else if (gate_we) begin
            // reserved bits never store anything
            sleep_gate_r <= impl_bits(reg_wdata);
        end
    end

    // auto clock gating control bit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            auto_gate_r <= 1'b0;
        end else if (ctrl_we) begin
            auto_gate_r <= reg_wdata[AUTO_CLOCK_GATING_BIT];
        end
    end

    // interrupt mask
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            evt_mask_r <= '0;
        end else if (mask_we) begin
            evt_mask_r <= reg_wdata[EVT_W-1:0];
        end
    end

    // events raised by this block
    always_comb begin
        evt_set                = '0;
        evt_set[EVT_FAULT]     = fault_nxt;
        evt_set[EVT_SLEEP_IN]  = sleep_enter;
        evt_set[EVT_SLEEP_OUT] = sleep_leave;
    end

    // write-one-to-clear; a new event in the same cycle survives
    always_comb begin
        evt_stat_nxt = evt_stat_r;
        for (int b = 0; b < EVT_W; b++) begin
            // set wins, so an event is never lost to a late clear
            if (evt_set[b]) begin
                evt_stat_nxt[b] = 1'b1;
            end else if (stat_we && reg_wdata[b]) begin
                evt_stat_nxt[b] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            evt_stat_r <= '0;
        end else begin
            evt_stat_r <= evt_stat_nxt;
        end
    end

    assign irq = |(evt_stat_r & evt_mask_r);

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_nxt = ZERO_WORD;
        if (reg_rd) begin
            case (reg_addr)
                SLEEP_GATE_OFF: begin
                    rdata_nxt = impl_bits(sleep_gate_r);
                end
                EVT_STAT_OFF: begin
                    rdata_nxt[EVT_W-1:0] = evt_stat_r;
                end
                EVT_MASK_OFF: begin
                    rdata_nxt[EVT_W-1:0] = evt_mask_r;
                end
                GATE_CTRL_OFF: begin
                    rdata_nxt[AUTO_CLOCK_GATING_BIT] = auto_gate_r;
                end
                default: begin
                    rdata_nxt = ZERO_WORD;
                end
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= ZERO_WORD;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // power mode tracking
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (sleep_req) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!sleep_req) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    assign sleep_enter = (state_r == ST_RUN) && sleep_req;
    assign sleep_leave = (state_r == ST_SLEEP) && !sleep_req;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // pick the gate source for the coming cycle;
    // without auto gating, sleep keeps the run-mode setting
    always_comb begin
        if ((state_nxt == ST_SLEEP) && auto_gate_r) begin
            gate_en_nxt = impl_bits(sleep_gate_r);
        end else begin
            gate_en_nxt = impl_bits(run_gate);
        end
    end

    // enables only change on a clock edge, so the downstream
    // gate cells never see a combinational glitch
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gate_en_r <= ZERO_WORD;
        end else begin
            gate_en_r <= gate_en_nxt;
        end
    end

    assign unit_clk_en  = gate_en_r;
    // disable is registered beside the enable so the two never
    // disagree, even for one cycle; spare positions stay out
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            disable_r <= GATE_IMPL_MASK;
        end else begin
            disable_r <= GATE_IMPL_MASK & ~gate_en_nxt;
        end
    end

    assign unit_disable = disable_r;

    // bus fault check against the enables in force this cycle;
    // an access in the switch cycle sees the old setting, which
    // is the one its unit was actually clocked by
    always_comb begin
        fault_nxt = 1'b0;
        if (unit_acc.req && is_unit(unit_acc.unit)) begin
            fault_nxt = ~gate_en_r[unit_acc.unit];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_r <= 1'b0;
        end else begin
            fault_r <= fault_nxt;
        end
    end

    assign unit_fault = fault_r;

endmodule : sleep_clock_gating

/* sleep_gate_pkg.sv */
/*
 * Shared constants and types for the sleep-mode clock gate block:
 * register offsets, field layout, reset values, event bits, states.
 * Assumes a 12-bit byte address inside the system control window.
 */
package sleep_gate_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int UNIT_W = 5;

    // system control window base, for software reference only
    localparam logic [31:0] SYS_CTRL_BASE = 32'h400f_e000;

    // register byte offsets
    localparam logic [ADDR_W-1:0] SLEEP_GATE_OFF = 12'h114;
    localparam logic [ADDR_W-1:0] EVT_STAT_OFF   = 12'h130;
    localparam logic [ADDR_W-1:0] EVT_MASK_OFF   = 12'h134;
    localparam logic [ADDR_W-1:0] GATE_CTRL_OFF  = 12'h138;

    // reset values
    localparam logic [DATA_W-1:0] SLEEP_GATE_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ZERO_WORD        = 32'h0000_0000;

    // gating bit positions
    localparam int COMPARATOR_B_GATE = 25;
    localparam int COMPARATOR_A_GATE = 24;
    localparam int GP_COUNTER_D_GATE = 19;
    localparam int GP_COUNTER_C_GATE = 18;
    localparam int GP_COUNTER_B_GATE = 17;
    localparam int GP_COUNTER_A_GATE = 16;
    localparam int TWO_WIRE_B_GATE   = 14;
    localparam int TWO_WIRE_A_GATE   = 12;
    localparam int SYNC_SERIAL_B_GATE  = 5;
    localparam int SYNC_SERIAL_A_GATE  = 4;
    localparam int ASYNC_SERIAL_C_GATE = 2;
    localparam int ASYNC_SERIAL_B_GATE = 1;
    localparam int ASYNC_SERIAL_A_GATE = 0;

    // writable (implemented) gating bits; every other bit is reserved
    localparam logic [DATA_W-1:0] GATE_IMPL_MASK = 32'h030f_5037;

    // control register fields
    localparam int AUTO_CLOCK_GATING_BIT = 0;

    // event bits in status and mask
    localparam int EVT_W         = 3;
    localparam int EVT_FAULT     = 0;
    localparam int EVT_SLEEP_IN  = 1;
    localparam int EVT_SLEEP_OUT = 2;

    // bus access toward a gated peripheral unit
    typedef struct packed {
        logic              req;
        logic              wr;
        logic [UNIT_W-1:0] unit;
    } unit_acc_type;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_SLEEP = 2'b01
    } pwr_state_type;

endpackage : sleep_gate_pkg

/* sleep_clock_gating_assertions.sv */
/* checker for the sleep clock gate block;
   assumes it sees only that block's ports */
`timescale 1ns/10ps
module sleep_clock_gating_checker
    import sleep_gate_pkg::*;
(
    input wire logic                      clk,
    input wire logic                      sys_rst,
    input wire logic [ADDR_W-1:0]         reg_addr,
    input wire logic [DATA_W-1:0]         reg_wdata,
    input wire logic                      reg_wr,
    input wire logic                      reg_rd,
    input wire logic [DATA_W-1:0]         reg_rdata,
    input wire sleep_gate_pkg::unit_acc_type unit_acc,
    input wire logic                      unit_fault,
    input wire logic [DATA_W-1:0]         unit_clk_en,
    input wire logic [DATA_W-1:0]         unit_disable,
    input wire logic                      sleep_req,
    input wire logic [DATA_W-1:0]         run_gate
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_gw; reg_wr && reg_addr == SLEEP_GATE_OFF; endsequence
    sequence s_gr; reg_rd && reg_addr == SLEEP_GATE_OFF; endsequence
    property p_wr_rd;
        s_gw ##1 s_gr |=> reg_rdata == ($past(reg_wdata, 2) & GATE_IMPL_MASK);
    endproperty
    property p_rd_res;
        s_gr |=> (reg_rdata & ~GATE_IMPL_MASK) == 32'h0;
    endproperty
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    property p_dis;
        unit_disable == (GATE_IMPL_MASK & ~unit_clk_en);
    endproperty
    property p_spare;
        (unit_clk_en & ~GATE_IMPL_MASK) == 32'h0;
    endproperty
    property p_fault;
        unit_acc.req && GATE_IMPL_MASK[unit_acc.unit] && !unit_clk_en[unit_acc.unit]
            |=> unit_fault;
    endproperty
    property p_no_fault;
        unit_acc.req && !(GATE_IMPL_MASK[unit_acc.unit] && !unit_clk_en[unit_acc.unit])
            |=> !unit_fault;
    endproperty
    property p_no_req;
        !unit_acc.req |=> !unit_fault;
    endproperty
    property p_run;
        !sleep_req |=> unit_clk_en == ($past(run_gate) & GATE_IMPL_MASK);
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("gate readback wrong");
    a_rd_res: assert property (p_rd_res) else $error("reserved bit read one");
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    a_dis: assert property (p_dis) else $error("disable not inverse");
    a_spare: assert property (p_spare) else $error("spare enable set");
    a_fault: assert property (p_fault) else $error("fault answer wrong");
    a_no_req: assert property (p_no_req) else $error("fault without access");
    a_no_fault: assert property (p_no_fault) else $error("fault on clocked unit");
    a_run: assert property (p_run) else $error("run enables wrong");
endmodule : sleep_clock_gating_checker
bind sleep_clock_gating sleep_clock_gating_checker u_chk (.clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .unit_acc, .unit_fault, .unit_clk_en,
    .unit_disable, .sleep_req, .run_gate);

/* sleep_clock_gating_bench.sv */
/* self-checking bench for the sleep clock gate block;
   assumes the block and its package are compiled first */
`timescale 1ns/10ps
module sleep_clock_gating_bench;
    import sleep_gate_pkg::*;
    // implemented gate bits rebuilt from the unit positions
    localparam logic [31:0] IMPL = (3 << 24) | (15 << 16) | (5 << 12) | (3 << 4) | 7;
    logic              clk, sys_rst, reg_wr, reg_rd, sleep_req, unit_fault, irq;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0]       reg_wdata, reg_rdata, run_gate, unit_clk_en, unit_disable, gw;
    unit_acc_type      unit_acc;
    int                miscompares, cmp_count, seed, i;
    sleep_clock_gating dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .run_gate, .sleep_req, .unit_acc, .unit_fault, .unit_clk_en,
        .unit_disable, .irq);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // each access clears its strobe at the edge, then waits 1 ns so the next may follow
    task automatic wr(logic [11:0] a, logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(logic [11:0] a, logic [31:0] exp, string what);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(what, exp, reg_rdata);
    endtask : rd
    task automatic step;
        @(posedge clk);
        #1;
    endtask : step
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        {sys_rst, reg_wr, reg_rd, sleep_req, reg_addr, reg_wdata, run_gate} = '0;
        sys_rst = 1'b1;
        unit_acc = '0;
        seed = 32'h42390c67;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        step();
        chk("clk_en", 32'h0, unit_clk_en);
        chk("disable", IMPL, unit_disable);
        rd(SLEEP_GATE_OFF, 32'h0, "gate reset");
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            gw = (i == 0) ? 32'hffff_ffff : $random(seed);
            wr(SLEEP_GATE_OFF, gw);
            rd(SLEEP_GATE_OFF, gw & IMPL, "gate rw");
        end
        rd(12'h118, 32'h0, "unmapped");
        $display("test register done");
        run_gate <= $random(seed);
        step();
        step();
        chk("run en", run_gate & IMPL, unit_clk_en);
        for (i = 0; i < 32; i++) begin
            unit_acc <= '{1'b1, i[0], i[4:0]};
            @(posedge clk);
            unit_acc.req <= 1'b0;
            #1 chk("fault", IMPL[i] & ~run_gate[i], unit_fault);
        end
        $display("test fault done");
        wr(EVT_STAT_OFF, 32'h7);
        wr(GATE_CTRL_OFF, 32'h1);
        gw = $random(seed);
        wr(SLEEP_GATE_OFF, gw & IMPL);
        wr(EVT_MASK_OFF, 32'h2);
        chk("irq idle", 32'h0, irq);
        sleep_req <= 1'b1;
        step();
        chk("sleep en", gw & IMPL, unit_clk_en);
        chk("sleep dis", IMPL & ~gw, unit_disable);
        chk("irq", 32'h1, irq);
        rd(EVT_STAT_OFF, 32'h2, "status");
        wr(EVT_STAT_OFF, 32'h2);
        chk("irq clear", 32'h0, irq);
        sleep_req <= 1'b0;
        step();
        chk("wake en", run_gate & IMPL, unit_clk_en);
        wr(GATE_CTRL_OFF, 32'h0);
        sleep_req <= 1'b1;
        step();
        chk("no auto en", run_gate & IMPL, unit_clk_en);
        $display("test sleep done");
        tally_and_finish();
    end
endmodule : sleep_clock_gating_bench
